/* design/dsi_pkg.sv */
// package for the drive state indication block: status word layout,
// state codes, register offset and the warning hold time.
// assumes a 25 MHz system clock.
package dsi_pkg;
   // operating states as numbered on the drive
   localparam logic [3:0] ST_START    = 4'h1;
   localparam logic [3:0] ST_NOT_RDY  = 4'h2;
   localparam logic [3:0] ST_SW_DIS   = 4'h3;
   localparam logic [3:0] ST_RDY      = 4'h4;
   localparam logic [3:0] ST_SW_ON    = 4'h5;
   localparam logic [3:0] ST_OP_EN    = 4'h6;
   localparam logic [3:0] ST_QSTOP    = 4'h7;
   localparam logic [3:0] ST_FLT_REAC = 4'h8;
   localparam logic [3:0] ST_FAULT    = 4'h9;

   // status word field positions
   localparam int B_RDY    = 0;
   localparam int B_SW_ON  = 1;
   localparam int B_OP_EN  = 2;
   localparam int B_FAULT  = 3;
   localparam int B_VOLT   = 4;
   localparam int B_QSTOP  = 5;
   localparam int B_SW_DIS = 6;
   localparam int B_WARN0  = 7;
   localparam int B_HALT   = 8;
   localparam int B_REMOTE = 9;
   localparam int B_TARGET = 10;
   localparam int B_LIMIT  = 11;
   localparam int B_MODE   = 12;
   localparam int B_PERR   = 13;
   localparam int B_PEND   = 14;
   localparam int B_ZERO   = 15;

   localparam logic [15:0] STATUS_OFFSET = 16'h1b04;
   localparam logic [15:0] STATUS_RESET  = 16'h0000;

   // minimum hold of the class-0 warning bit
   localparam int CLK_HZ       = 25_000_000;
   localparam int WARN_HOLD_MS = 100;
   localparam int WARN_HOLD_CYC = (CLK_HZ / 1000) * WARN_HOLD_MS;
endpackage

/* design/dsi_top.sv */
// drive state indication: encodes the operating state into two signal
// outputs and the read-only status word.
// assumes the state machine, warning list and motion logic sit outside
// and present their conditions as synchronous levels and pulses.
`timescale 1ns/1ps

// How it works
// - no-fault output high only in states 4, 5 and 6
// - active output high only in state 6
// - sixteen bit read-only status word, upper byte holds process flags
// - states 2, 3, 9 give bits 6,3,2,1,0 as 00000, 10000, 01000
// - states 4 to 8 give their fixed state bit patterns
// - bit 4 follows DC bus voltage correctness
// - transition 3 to 4 refused while DC bus voltage is low
// - bit 7 set on class-0 warning; movement not interrupted
// - bit 7 stays set while class-0 warning remains listed
// - bit 7 held at least 100 ms once set
// - fault reset clears bit 7 at once, overriding the hold
// - bit 14 clears on mode start, sets at standstill unless chained
// - bit 15 tracks valid zero point, survives power stage disable
module dsi_top #(
   parameter int WARN_HOLD_CYC = dsi_pkg::WARN_HOLD_CYC
) (
   input  wire logic        SYS_CLK_I,
   input  wire logic        RST_N_I,
   input  wire logic [3:0]  OP_STATE_I,
   input  wire logic        DC_BUS_OK_I,
   input  wire logic        REQ_3TO4_I,
   input  wire logic        WARN_CLASS0_I,
   input  wire logic        FAULT_RESET_I,
   input  wire logic        HALT_I,
   input  wire logic        REMOTE_I,
   input  wire logic        TARGET_I,
   input  wire logic        LIMIT_I,
   input  wire logic        MODE_BIT_I,
   input  wire logic        PROC_ERR_I,
   input  wire logic        MODE_START_I,
   input  wire logic        PROC_DONE_I,
   input  wire logic        STANDSTILL_I,
   input  wire logic        NEXT_MODE_I,
   input  wire logic        ZERO_VALID_I,
   input  wire logic        ZERO_LOST_I,
   input  wire logic [15:0] RD_ADDR_I,
   output logic [15:0]      RD_DATA_O,
   output logic [15:0]      STATUS_O,
   output logic             ALLOW_3TO4_O,
   output logic             NO_FAULT_O,
   output logic             ACTIVE_O
);
   localparam int CW = $clog2(WARN_HOLD_CYC + 1);

   // elaboration check: a zero hold could never be counted down
   if (WARN_HOLD_CYC < 1) begin : g_hold_chk
      $error("WARN_HOLD_CYC must be at least 1");
   end

   // state flag pattern as bits 6,5,3,2,1,0 packed into status layout
   function automatic logic [6:0] dsi_state_bits(input logic [3:0] st);
      logic [6:0] b;
      b = 7'h00;
      case (st)
         dsi_pkg::ST_SW_DIS:   b = 7'h40;
         dsi_pkg::ST_RDY:      b = 7'h21;
         dsi_pkg::ST_SW_ON:    b = 7'h23;
         dsi_pkg::ST_OP_EN:    b = 7'h27;
         dsi_pkg::ST_QSTOP:    b = 7'h07;
         dsi_pkg::ST_FLT_REAC: b = 7'h0f;
         dsi_pkg::ST_FAULT:    b = 7'h08;
         default:              b = 7'h00; // start and not ready
      endcase
      return b;
   endfunction

   logic          no_fault_q;
   logic          active_q;
   logic          allow_q;
   logic          warn_q;
   logic [CW-1:0] hold_q;
   logic          pend_q;
   logic          pend_wait_q;
   logic          zero_q;
   logic [15:0]   status_q;
   logic [15:0]   rd_q;
   logic [15:0]   status_d;

   // signal outputs decoded straight from the state number
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         no_fault_q <= 1'b0;
         active_q   <= 1'b0;
      end else begin
         no_fault_q <= (OP_STATE_I == dsi_pkg::ST_RDY) ||
                       (OP_STATE_I == dsi_pkg::ST_SW_ON) ||
                       (OP_STATE_I == dsi_pkg::ST_OP_EN);
         active_q   <= (OP_STATE_I == dsi_pkg::ST_OP_EN);
      end
   end

   // permission for the state machine to leave switch on disabled
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         allow_q <= 1'b0;
      end else begin
         allow_q <= REQ_3TO4_I && DC_BUS_OK_I &&
                    (OP_STATE_I == dsi_pkg::ST_SW_DIS);
      end
   end

   // class-0 warning with minimum hold; fault reset wins over warning
   // so a stale hold never masks a fresh reset. warning does not
   // feed any motion path here.
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         warn_q <= 1'b0;
         hold_q <= '0;
      end else if (FAULT_RESET_I) begin
         warn_q <= 1'b0;
         hold_q <= '0;
      end else if (WARN_CLASS0_I) begin
         warn_q <= 1'b1;
         if (!warn_q) begin
            hold_q <= CW'(WARN_HOLD_CYC - 1);
         end else if (hold_q != '0) begin
            hold_q <= hold_q - CW'(1);
         end
      end else if (hold_q != '0) begin
         hold_q <= hold_q - CW'(1);
      end else begin
         warn_q <= 1'b0;
      end
   end

   // process end: start clears, standstill after done sets again
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         pend_q      <= 1'b1;
         pend_wait_q <= 1'b0;
      end else if (MODE_START_I) begin
         pend_q      <= 1'b0;
         pend_wait_q <= 1'b0;
      end else if (PROC_DONE_I && !NEXT_MODE_I) begin
         pend_wait_q <= 1'b1;
         if (STANDSTILL_I) begin
            pend_q      <= 1'b1;
            pend_wait_q <= 1'b0;
         end
      end else if (pend_wait_q && STANDSTILL_I) begin
         pend_q      <= 1'b1;
         pend_wait_q <= 1'b0;
      end
   end

   // zero point latch; only loss of reference clears it, not disable
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         zero_q <= 1'b0;
      end else if (ZERO_VALID_I) begin
         zero_q <= 1'b1;
      end else if (ZERO_LOST_I) begin
         zero_q <= 1'b0;
      end
   end

   // status word assembly
   always_comb begin
      status_d = {9'h000, dsi_state_bits(OP_STATE_I)};
      status_d[dsi_pkg::B_VOLT]   = DC_BUS_OK_I;
      status_d[dsi_pkg::B_WARN0]  = warn_q;
      status_d[dsi_pkg::B_HALT]   = HALT_I;
      status_d[dsi_pkg::B_REMOTE] = REMOTE_I;
      status_d[dsi_pkg::B_TARGET] = TARGET_I;
      status_d[dsi_pkg::B_LIMIT]  = LIMIT_I;
      status_d[dsi_pkg::B_MODE]   = MODE_BIT_I;
      status_d[dsi_pkg::B_PERR]   = PROC_ERR_I;
      status_d[dsi_pkg::B_PEND]   = pend_q;
      status_d[dsi_pkg::B_ZERO]   = zero_q;
   end

   // registered status and read port; unmapped address reads zero
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         status_q <= dsi_pkg::STATUS_RESET;
         rd_q     <= 16'h0000;
      end else begin
         status_q <= status_d;
         rd_q     <= (RD_ADDR_I == dsi_pkg::STATUS_OFFSET) ?
                     status_d : 16'h0000;
      end
   end

   assign RD_DATA_O    = rd_q;
   assign STATUS_O     = status_q;
   assign ALLOW_3TO4_O = allow_q;
   assign NO_FAULT_O   = no_fault_q;
   assign ACTIVE_O     = active_q;

   sequence s_warn_rise;
      !warn_q ##1 warn_q;
   endsequence

   // checker helper: cycles bit 7 has stood since it last rose, saturating
   // at the hold so the counter never wraps on long warnings
   logic [CW-1:0] warn_age_q;

   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         warn_age_q <= '0;
      end else if (!warn_q) begin
         warn_age_q <= '0;
      end else if (warn_age_q != CW'(WARN_HOLD_CYC)) begin
         warn_age_q <= warn_age_q + CW'(1);
      end
   end

   // signal outputs
   AST_NOFAULT: assert property (@(posedge SYS_CLK_I)
      disable iff (!RST_N_I)
      1'b1 |=> NO_FAULT_O == ($past(OP_STATE_I) inside {4'h4, 4'h5, 4'h6}))
      else $error("no-fault output wrong for state");
   AST_ACTIVE: assert property (@(posedge SYS_CLK_I)
      disable iff (!RST_N_I)
      1'b1 |=> ACTIVE_O == ($past(OP_STATE_I) == dsi_pkg::ST_OP_EN))
      else $error("active output wrong for state");
   AST_ACTIVE_ST: assert property (@(posedge SYS_CLK_I)
      disable iff (!RST_N_I)
      OP_STATE_I == 4'h6 |=> ACTIVE_O)
      else $error("active low in operation enabled");

   // state bit patterns 6,5,3,2,1,0, one check per state except state 5 (switched on)
   AST_START: assert property (@(posedge SYS_CLK_I)
      disable iff (!RST_N_I)
      OP_STATE_I == 4'h1 |=> {STATUS_O[6:5], STATUS_O[3:0]} == 6'b000000)
      else $error("start pattern wrong");
   AST_NOTRDY: assert property (@(posedge SYS_CLK_I)
      disable iff (!RST_N_I)
      OP_STATE_I == 4'h2 |=> {STATUS_O[6:5], STATUS_O[3:0]} == 6'b000000)
      else $error("not ready pattern wrong");
   AST_SWDIS: assert property (@(posedge SYS_CLK_I)
      disable iff (!RST_N_I)
      OP_STATE_I == 4'h3 |=> {STATUS_O[6:5], STATUS_O[3:0]} == 6'b100000)
      else $error("switch on disabled pattern wrong");
   AST_RDY: assert property (@(posedge SYS_CLK_I)
      disable iff (!RST_N_I)
      OP_STATE_I == 4'h4 |=> {STATUS_O[6:5], STATUS_O[3:0]} == 6'b010001)
      else $error("ready pattern wrong");
   AST_OPEN: assert property (@(posedge SYS_CLK_I)
      disable iff (!RST_N_I)
      OP_STATE_I == 4'h6 |=> {STATUS_O[6:5], STATUS_O[3:0]} == 6'b010111)
      else $error("operation enabled pattern wrong");
   AST_QSTOP: assert property (@(posedge SYS_CLK_I)
      disable iff (!RST_N_I)
      OP_STATE_I == 4'h7 |=> {STATUS_O[6:5], STATUS_O[3:0]} == 6'b000111)
      else $error("quick stop pattern wrong");
   AST_FLTREAC: assert property (@(posedge SYS_CLK_I)
      disable iff (!RST_N_I)
      OP_STATE_I == 4'h8 |=> {STATUS_O[6:5], STATUS_O[3:0]} == 6'b001111)
      else $error("fault reaction pattern wrong");
   AST_FAULT: assert property (@(posedge SYS_CLK_I)
      disable iff (!RST_N_I)
      OP_STATE_I == 4'h9 |=> {STATUS_O[6:5], STATUS_O[3:0]} == 6'b001000)
      else $error("fault pattern wrong");

   // voltage, permission, flag copies and read port
   AST_VOLT: assert property (@(posedge SYS_CLK_I)
      disable iff (!RST_N_I)
      1'b1 |=> STATUS_O[4] == $past(DC_BUS_OK_I))
      else $error("voltage bit wrong");
   AST_NO34: assert property (@(posedge SYS_CLK_I)
      disable iff (!RST_N_I)
      !DC_BUS_OK_I |=> !ALLOW_3TO4_O)
      else $error("3 to 4 allowed at low voltage");
   AST_ALLOW: assert property (@(posedge SYS_CLK_I)
      disable iff (!RST_N_I)
      REQ_3TO4_I && DC_BUS_OK_I && OP_STATE_I == 4'h3 |=> ALLOW_3TO4_O)
      else $error("3 to 4 refused with good voltage");
   AST_UPPER: assert property (@(posedge SYS_CLK_I)
      disable iff (!RST_N_I)
      1'b1 |=> STATUS_O[13:8] == $past({PROC_ERR_I, MODE_BIT_I, LIMIT_I,
                                         TARGET_I, REMOTE_I, HALT_I}))
      else $error("process flag bits wrong");
   AST_RDMAP: assert property (@(posedge SYS_CLK_I)
      disable iff (!RST_N_I)
      RD_ADDR_I == dsi_pkg::STATUS_OFFSET |=> RD_DATA_O == STATUS_O)
      else $error("status read differs from status word");
   AST_RDUNMAP: assert property (@(posedge SYS_CLK_I)
      disable iff (!RST_N_I)
      RD_ADDR_I != dsi_pkg::STATUS_OFFSET |=> RD_DATA_O == 16'h0000)
      else $error("unmapped read not zero");

   // class-0 warning bit
   AST_WARNSET: assert property (@(posedge SYS_CLK_I)
      disable iff (!RST_N_I)
      WARN_CLASS0_I && !FAULT_RESET_I |=> warn_q)
      else $error("warning bit not set");
   AST_KEEP: assert property (@(posedge SYS_CLK_I)
      disable iff (!RST_N_I)
      warn_q && WARN_CLASS0_I && !FAULT_RESET_I |=> warn_q)
      else $error("warning bit dropped while listed");
   AST_HOLD: assert property (@(posedge SYS_CLK_I)
      disable iff (!RST_N_I)
      s_warn_rise ##0 !FAULT_RESET_I [*8] |-> warn_q)
      else $error("warning bit dropped inside hold");
   AST_HOLD_AGE: assert property (@(posedge SYS_CLK_I)
      disable iff (!RST_N_I)
      warn_q && !FAULT_RESET_I && warn_age_q < CW'(WARN_HOLD_CYC - 1)
      |=> warn_q)
      else $error("warning bit shorter than minimum hold");
   AST_FRST: assert property (@(posedge SYS_CLK_I)
      disable iff (!RST_N_I)
      FAULT_RESET_I |=> !warn_q ##1 !STATUS_O[7])
      else $error("fault reset did not clear warning");

   // process end and zero point
   AST_PEND: assert property (@(posedge SYS_CLK_I)
      disable iff (!RST_N_I)
      MODE_START_I |=> !pend_q)
      else $error("process end not cleared on start");
   AST_PEND_SET: assert property (@(posedge SYS_CLK_I)
      disable iff (!RST_N_I)
      pend_wait_q && STANDSTILL_I && !MODE_START_I |=> pend_q)
      else $error("process end not set at standstill");
   AST_ZERO: assert property (@(posedge SYS_CLK_I)
      disable iff (!RST_N_I)
      zero_q && !ZERO_LOST_I |=> zero_q)
      else $error("zero point lost without cause");
   AST_ZEROSET: assert property (@(posedge SYS_CLK_I)
      disable iff (!RST_N_I)
      ZERO_VALID_I |=> zero_q)
      else $error("zero point not taken");
endmodule

/* test/dsi_master.sv */
// fieldbus master model: polls the status word or an unmapped address.
// assumes read data returns one cycle after the address is presented.
`timescale 1ns/1ps
module dsi_master (
   input  wire logic   clk_i,
   input  wire logic   unmapped_i,
   output logic [15:0] addr_o
);
   // address moves only just after an edge, never mid-cycle
   always @(posedge clk_i) begin
      addr_o <= unmapped_i ? 16'h1b06 : dsi_pkg::STATUS_OFFSET;
   end
endmodule

/* test/drive_state_indication_tb_top.sv */
// self-checking bench for the drive state indication block.
// assumes a short warning hold so the hold can be seen in full.
`timescale 1ns/1ps
module drive_state_indication_tb_top;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [3:0]  st = 4'h0;
   logic        ok = 0, req = 0, warn = 0, frst = 0, halt = 0, rem = 0;
   logic        tgt = 0, lim = 0, mb = 0, perr = 0, mst = 0, pdone = 0;
   logic        sstill = 0, nxt = 0, zv = 0, zl = 0, unm = 0;
   logic [15:0] addr, rdata, status, e;
   logic        allow, nofault, active;
   logic [31:0] seed = 32'd45;
   logic [31:0] r;
   int          n_mismatch = 0, tests_run = 0, cyc = 0;
   always #20 clk = ~clk;
   dsi_master master (.clk_i(clk), .unmapped_i(unm), .addr_o(addr));
   localparam int HOLD = 20; // short hold so the whole window is seen
   dsi_top #(.WARN_HOLD_CYC(HOLD)) dut (.SYS_CLK_I(clk), .RST_N_I(rst_n),
      .OP_STATE_I(st), .DC_BUS_OK_I(ok), .REQ_3TO4_I(req),
      .WARN_CLASS0_I(warn), .FAULT_RESET_I(frst), .HALT_I(halt),
      .REMOTE_I(rem), .TARGET_I(tgt), .LIMIT_I(lim), .MODE_BIT_I(mb),
      .PROC_ERR_I(perr), .MODE_START_I(mst), .PROC_DONE_I(pdone),
      .STANDSTILL_I(sstill), .NEXT_MODE_I(nxt), .ZERO_VALID_I(zv),
      .ZERO_LOST_I(zl), .RD_ADDR_I(addr), .RD_DATA_O(rdata),
      .STATUS_O(status), .ALLOW_3TO4_O(allow), .NO_FAULT_O(nofault),
      .ACTIVE_O(active));
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // state bits 6..0 with the voltage bit; unlisted states read zero
   function automatic logic [15:0] exp_low(input logic [3:0] s,
                                           input logic v);
      logic [6:0] p;
      case (s)
         4'h3: p = 7'h40;
         4'h4: p = 7'h21;
         4'h5: p = 7'h23;
         4'h6: p = 7'h27;
         4'h7: p = 7'h07;
         4'h8: p = 7'h0f;
         4'h9: p = 7'h08;
         default: p = 7'h00;
      endcase
      return {9'h000, p | {2'b00, v, 4'h0}};
   endfunction
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // two register stages at most, so three edges always suffice
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask
   task automatic end_of_test;
      if (n_mismatch == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // hang guard, well above the few hundred cycles the tests need
   always @(posedge clk) begin
      cyc++;
      if (cyc == 6000) begin
         n_mismatch++;
         end_of_test();
      end
   end
   initial begin
      settle(6);
      chk(status, 16'h0000);
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      // all state codes at low then good voltage, then random mixes
      for (int i = 0; i < 80; i++) begin
         r = xs();
         @(posedge clk);
         st <= (i < 32) ? 4'(i) : r[3:0];
         ok <= (i < 32) ? i[4] : r[4];
         req <= (i < 32) ? 1'b1 : r[5];
         {halt, rem, tgt, lim, mb, perr} <= r[11:6];
         unm <= r[12];
         settle(3);
         e = exp_low(st, ok) | {2'b01, perr, mb, lim, tgt, rem, halt, 8'h00};
         chk(status, e);
         chk(rdata, unm ? 16'h0000 : e);
         chk(16'(nofault), 16'(st inside {4'h4, 4'h5, 4'h6}));
         chk(16'(active), 16'(st == 4'h6));
         chk(16'(allow), 16'(st == 4'h3 && ok && req));
      end
      @(posedge clk);
      st <= 4'h6;
      warn <= 1'b1;
      @(posedge clk);
      warn <= 1'b0;
      settle(3);
      chk(16'(status[7]), 16'h1);
      chk(16'(active), 16'h1);
      // last cycle of the hold, then the first one after it
      settle(HOLD - 3);
      chk(16'(status[7]), 16'h1);
      settle(1);
      chk(16'(status[7]), 16'h0);
      @(posedge clk);
      warn <= 1'b1;
      settle(30);
      chk(16'(status[7]), 16'h1);
      @(posedge clk);
      warn <= 1'b0;
      settle(3);
      chk(16'(status[7]), 16'h0);
      // fresh warning, then fault reset while its hold still runs
      @(posedge clk);
      warn <= 1'b1;
      @(posedge clk);
      warn <= 1'b0;
      frst <= 1'b1;
      @(posedge clk);
      frst <= 1'b0;
      settle(3);
      chk(16'(status[7]), 16'h0);
      // process end bit: cleared on start, set at standstill unless chained
      // k=0 standstill at once, k=1 chained mode, k=2 standstill later
      for (int k = 0; k < 3; k++) begin
         @(posedge clk);
         mst <= 1'b1;
         sstill <= 1'b0;
         @(posedge clk);
         mst <= 1'b0;
         settle(3);
         chk(16'(status[14]), 16'h0);
         @(posedge clk);
         pdone <= 1'b1;
         sstill <= (k != 2);
         nxt <= (k == 1);
         @(posedge clk);
         pdone <= 1'b0;
         settle(3);
         chk(16'(status[14]), 16'(k == 0));
         @(posedge clk);
         sstill <= 1'b1;
         settle(3);
         chk(16'(status[14]), 16'(k != 1));
      end
      @(posedge clk);
      nxt <= 1'b0;
      zv <= 1'b1;
      @(posedge clk);
      zv <= 1'b0;
      st <= 4'h3;
      settle(3);
      chk(16'(status[15]), 16'h1);
      @(posedge clk);
      zl <= 1'b1;
      @(posedge clk);
      zl <= 1'b0;
      settle(3);
      chk(16'(status[15]), 16'h0);
      end_of_test();
   end
endmodule
